// ### src/ibcf_flags.v
// Start/stop detection, bus-busy and flag register of the I2C bus interface
`timescale 1ns/100ps
`include "ibcf_defines.vh"

module ibcf_flags
(
   input  wire                     clk_in,
   input  wire                     sys_rst_in,
   input  wire                     scl_in,
   input  wire                     sda_in,
   input  wire                     interface_enable_in,
   input  wire                     communication_exit_request_in,
   input  wire                     start_request_set_in,
   input  wire                     start_done_in,
   input  wire [`IBCF_ADDR_W-1:0]  reg_addr_in,
   input  wire [7:0]               reg_wdata_in,
   input  wire                     reg_wr_in,
   input  wire                     reg_rd_in,
   output reg  [7:0]               reg_rdata_out,
   output wire                     start_detected_flag_out,
   output wire                     stop_detected_flag_out,
   output wire                     start_request_out,
   output wire                     start_allowed_out,
   output wire [7:0]               flag_register_out
);

   // Pin synchronisers, three stages each
   reg        scl_s1_r;
   reg        scl_s2_r;
   reg        scl_s3_r;
   reg        sda_s1_r;
   reg        sda_s2_r;
   reg        sda_s3_r;
   reg        scl_lvl_r;
   reg        sda_lvl_r;
   reg        scl_lvl_nxt;
   reg        sda_lvl_nxt;

   // Flag state
   reg        start_detected_flag_r;
   reg        start_detected_flag_nxt;
   reg        stop_detected_flag_r;
   reg        stop_detected_flag_nxt;
   reg        start_failure_flag_r;
   reg        start_failure_flag_nxt;
   reg        bus_busy_flag_r;
   reg        bus_busy_flag_nxt;
   reg        initial_start_enable_r;
   reg        initial_start_enable_nxt;
   reg        reservation_disable_r;
   reg        reservation_disable_nxt;
   reg        start_request_r;
   reg        start_request_nxt;
   reg        enable_d_r;
   reg        in_frame_r;
   reg        in_frame_nxt;
   reg [`IBCF_CLK_W-1:0] clk_cnt_r;
   reg [`IBCF_CLK_W-1:0] clk_cnt_nxt;

   wire       flag_hit;
   wire       flag_wr;
   wire       start_cond;
   wire       stop_cond;
   wire       scl_rise;
   wire       enable_rise;
   wire       enable_fall;
   wire       start_fail;
   wire [7:0] flag_rst_val;

   assign flag_rst_val = `IBCF_FLAG_RST;

   // Levels only move once the last two stages agree, so a one-sample glitch never counts
   always @*
   begin
      scl_lvl_nxt = scl_lvl_r;
      sda_lvl_nxt = sda_lvl_r;
      if (scl_s2_r == scl_s3_r)
      begin
         scl_lvl_nxt = scl_s3_r;
      end
      if (sda_s2_r == sda_s3_r)
      begin
         sda_lvl_nxt = sda_s3_r;
      end
   end

   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         scl_s1_r  <= 1'b1;
         scl_s2_r  <= 1'b1;
         scl_s3_r  <= 1'b1;
         sda_s1_r  <= 1'b1;
         sda_s2_r  <= 1'b1;
         sda_s3_r  <= 1'b1;
         scl_lvl_r <= 1'b1;
         sda_lvl_r <= 1'b1;
      end
      else
      begin
         scl_s1_r  <= scl_in;
         scl_s2_r  <= scl_s1_r;
         scl_s3_r  <= scl_s2_r;
         sda_s1_r  <= sda_in;
         sda_s2_r  <= sda_s1_r;
         sda_s3_r  <= sda_s2_r;
         scl_lvl_r <= scl_lvl_nxt;
         sda_lvl_r <= sda_lvl_nxt;
      end
   end

   // Conditions are seen only while the interface is enabled
   assign start_cond  = interface_enable_in & scl_lvl_r & scl_lvl_nxt & sda_lvl_r & ~sda_lvl_nxt;
   assign stop_cond   = interface_enable_in & scl_lvl_r & scl_lvl_nxt & ~sda_lvl_r & sda_lvl_nxt;
   assign scl_rise    = interface_enable_in & ~scl_lvl_r & scl_lvl_nxt;
   assign enable_rise = interface_enable_in & ~enable_d_r;
   assign enable_fall = ~interface_enable_in & enable_d_r;

   // Busy already encodes the stop-first policy after enabling
   // start gating
   assign start_allowed_out = interface_enable_in & ~bus_busy_flag_r;

   assign start_fail = start_request_r & reservation_disable_r & ~start_allowed_out;

   assign flag_hit = (reg_addr_in == `IBCF_FLAG_ADDR);
   assign flag_wr  = reg_wr_in & flag_hit;

   // Clock counter within the frame: 0 before the first address clock
   always @*
   begin
      clk_cnt_nxt  = clk_cnt_r;
      in_frame_nxt = in_frame_r;
      if (start_cond)
      begin
         clk_cnt_nxt  = {`IBCF_CLK_W{1'b0}};
         in_frame_nxt = 1'b1;
      end
      else if (stop_cond | ~interface_enable_in | communication_exit_request_in)
      begin
         clk_cnt_nxt  = {`IBCF_CLK_W{1'b0}};
         in_frame_nxt = 1'b0;
      end
      else if (scl_rise & in_frame_r & (clk_cnt_r != `IBCF_CLK_SAT))
      begin
         clk_cnt_nxt = clk_cnt_r + 4'h1;
      end
   end

   always @*
   begin
      start_detected_flag_nxt = start_detected_flag_r;
      if (enable_fall | stop_cond | communication_exit_request_in)
      begin
         start_detected_flag_nxt = 1'b0;
      end
      else if (scl_rise & in_frame_r & (clk_cnt_r == `IBCF_ADDR_CLOCKS))
      begin
         start_detected_flag_nxt = 1'b0;
      end
      if (start_cond)
      begin
         start_detected_flag_nxt = 1'b1;
      end
   end

   always @*
   begin
      stop_detected_flag_nxt = stop_detected_flag_r;
      if (enable_fall)
      begin
         stop_detected_flag_nxt = 1'b0;
      end
      else if (scl_rise & in_frame_r & (clk_cnt_r == {`IBCF_CLK_W{1'b0}}))
      begin
         stop_detected_flag_nxt = 1'b0;
      end
      if (stop_cond)
      begin
         stop_detected_flag_nxt = 1'b1;
      end
   end

   always @*
   begin
      bus_busy_flag_nxt = bus_busy_flag_r;
      if (~interface_enable_in | stop_cond)
      begin
         bus_busy_flag_nxt = 1'b0;
      end
      else if (start_cond | (enable_rise & ~initial_start_enable_r))
      begin
         bus_busy_flag_nxt = 1'b1;
      end
   end

   always @*
   begin
      start_request_nxt      = start_request_r;
      start_failure_flag_nxt = start_failure_flag_r;
      if (start_request_set_in)
      begin
         start_request_nxt      = 1'b1;
         start_failure_flag_nxt = 1'b0;
      end
      else if (start_done_in | ~interface_enable_in)
      begin
         start_request_nxt = 1'b0;
      end
      if (~interface_enable_in)
      begin
         start_failure_flag_nxt = 1'b0;
         start_request_nxt      = 1'b0;
      end
      else if (start_fail & ~start_request_set_in)
      begin
         start_request_nxt      = 1'b0;
         start_failure_flag_nxt = 1'b1;
      end
   end

   // Config writes are dropped while enabled rather than corrupt a transfer; a start condition still clears initial start enable
   always @*
   begin
      initial_start_enable_nxt = initial_start_enable_r;
      reservation_disable_nxt  = reservation_disable_r;
      if (flag_wr & ~interface_enable_in)
      begin
         reservation_disable_nxt  = reg_wdata_in[`IBCF_BIT_RSV_DIS];
         initial_start_enable_nxt = reg_wdata_in[`IBCF_BIT_INIT_START];
      end
      else if (start_cond)
      begin
         initial_start_enable_nxt = 1'b0;
      end
   end

   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         start_failure_flag_r   <= flag_rst_val[`IBCF_BIT_FAIL];
         bus_busy_flag_r        <= flag_rst_val[`IBCF_BIT_BUSY];
         initial_start_enable_r <= flag_rst_val[`IBCF_BIT_INIT_START];
         reservation_disable_r  <= flag_rst_val[`IBCF_BIT_RSV_DIS];
         start_detected_flag_r  <= 1'b0;
         stop_detected_flag_r   <= 1'b0;
         start_request_r        <= 1'b0;
         enable_d_r             <= 1'b0;
         in_frame_r             <= 1'b0;
         clk_cnt_r              <= {`IBCF_CLK_W{1'b0}};
         reg_rdata_out          <= 8'h00;
      end
      else
      begin
         start_failure_flag_r   <= start_failure_flag_nxt;
         bus_busy_flag_r        <= bus_busy_flag_nxt;
         initial_start_enable_r <= initial_start_enable_nxt;
         reservation_disable_r  <= reservation_disable_nxt;
         start_detected_flag_r  <= start_detected_flag_nxt;
         stop_detected_flag_r   <= stop_detected_flag_nxt;
         start_request_r        <= start_request_nxt;
         enable_d_r             <= interface_enable_in;
         in_frame_r             <= in_frame_nxt;
         clk_cnt_r              <= clk_cnt_nxt;
         if (reg_rd_in)
         begin
            reg_rdata_out <= flag_hit ? flag_register_out : `IBCF_RDATA_UNMAPPED;
         end
      end
   end

   assign flag_register_out = {start_failure_flag_r, bus_busy_flag_r, 4'h0,
                               initial_start_enable_r, reservation_disable_r};

   assign start_detected_flag_out = start_detected_flag_r;
   assign stop_detected_flag_out  = stop_detected_flag_r;
   assign start_request_out       = start_request_r;

endmodule // ibcf_flags

// ### src/ibcf_defines.vh
// Constants for the bus condition and flag block
`ifndef IBCF_DEFINES_VH
`define IBCF_DEFINES_VH

`define IBCF_ADDR_W          20
`define IBCF_FLAG_ADDR       20'hFFF52
`define IBCF_FLAG_RST        8'h00
`define IBCF_RDATA_UNMAPPED  8'h00

`define IBCF_BIT_FAIL        7
`define IBCF_BIT_BUSY        6
`define IBCF_BIT_INIT_START  1
`define IBCF_BIT_RSV_DIS     0

`define IBCF_CLK_W           4
`define IBCF_ADDR_CLOCKS     4'h9
`define IBCF_CLK_SAT         4'hF

`endif

// ### tb/ibcf_flags_monitor.sv
// Port checker for the bus condition and flag block
`timescale 1ns/100ps
`include "ibcf_defines.vh"
module ibcf_flags_monitor
(
   input wire                    clk_in,
   input wire                    sys_rst_in,
   input wire                    interface_enable_in,
   input wire                    communication_exit_request_in,
   input wire                    start_request_set_in,
   input wire                    start_done_in,
   input wire [`IBCF_ADDR_W-1:0] reg_addr_in,
   input wire [7:0]              reg_wdata_in,
   input wire                    reg_wr_in,
   input wire                    reg_rd_in,
   input wire [7:0]              reg_rdata_out,
   input wire                    start_detected_flag_out,
   input wire                    stop_detected_flag_out,
   input wire                    start_request_out,
   input wire                    start_allowed_out,
   input wire [7:0]              flag_register_out
);
   wire [7:0] f = flag_register_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_pend;
      start_request_out && f[0] && f[6] && interface_enable_in && !start_request_set_in
         && !start_done_in;
   endsequence
   sequence s_exit;
      interface_enable_in && communication_exit_request_in;
   endsequence
   property p_rsv_hold; reg_wr_in && interface_enable_in |=> $stable(f[0]); endproperty
   property p_wr; reg_wr_in && reg_addr_in == `IBCF_FLAG_ADDR && !interface_enable_in
      |=> f[1:0] == $past(reg_wdata_in[1:0]); endproperty
   property p_zero; f[5:2] == 4'h0; endproperty
   property p_dis; !interface_enable_in |=> f[7:6] == 2'h0; endproperty
   property p_req; interface_enable_in && start_request_set_in && !start_done_in
      |=> start_request_out && !f[7]; endproperty
   property p_fail; s_pend |=> f[7] && !start_request_out; endproperty
   property p_allow; $rose(interface_enable_in) && !f[1] |=> !start_allowed_out && f[6];
   endproperty
   property p_start; $rose(start_detected_flag_out) |-> f[6] && !f[1]; endproperty
   property p_stop; $rose(stop_detected_flag_out) |-> !f[6] && !start_detected_flag_out;
   endproperty
   property p_exit; s_exit |=> !start_detected_flag_out; endproperty
   property p_unm; reg_rd_in && reg_addr_in != `IBCF_FLAG_ADDR
      |=> reg_rdata_out == `IBCF_RDATA_UNMAPPED; endproperty
   a_rsv_hold: assert property (p_rsv_hold) else $error("config bit moved while enabled");
   a_wr: assert property (p_wr) else $error("config write lost");
   a_zero: assert property (p_zero) else $error("unused bits not zero");
   a_dis: assert property (p_dis) else $error("busy or fail kept while disabled");
   a_req: assert property (p_req) else $error("request write not taken");
   a_fail: assert property (p_fail) else $error("failed start not flagged");
   a_allow: assert property (p_allow) else $error("start allowed before stop");
   a_start: assert property (p_start) else $error("start without busy");
   a_stop: assert property (p_stop) else $error("stop kept busy");
   a_exit: assert property (p_exit) else $error("exit kept start flag");
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // ibcf_flags_monitor
bind ibcf_flags ibcf_flags_monitor u_mon (.clk_in, .sys_rst_in, .interface_enable_in,
   .communication_exit_request_in, .start_request_set_in, .start_done_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .start_detected_flag_out,
   .stop_detected_flag_out, .start_request_out, .start_allowed_out, .flag_register_out);

// ### tb/ibcf_bus_model.sv
// Far-side bus master model making start, stop and clock pulses
`timescale 1ns/100ps
module ibcf_bus_model
(
   output logic scl_out,
   output logic sda_out
);
   // Released lines sit at the pulled-up level
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task start;
      sda_out = 1'b0;
      #100;
      scl_out = 1'b0;
      #100;
   endtask
   // Data held low while the link clock is high, so no false conditions
   task clocks(input int n);
      repeat (n)
      begin
         scl_out = 1'b1;
         #100;
         scl_out = 1'b0;
         #100;
      end
   endtask
   task stop;
      scl_out = 1'b0;
      #50;
      sda_out = 1'b0;
      #50;
      scl_out = 1'b1;
      #100;
      sda_out = 1'b1;
      #100;
   endtask
endmodule // ibcf_bus_model

// ### tb/ibcf_flags_tb.sv
// Testbench of the bus condition and flag block
`timescale 1ns/100ps
`include "ibcf_defines.vh"
module ibcf_flags_tb;
   logic clk_in = 0, sys_rst_in = 1, en = 0, ex = 0, rq = 0, dn = 0, wr = 0, rd = 0;
   logic [19:0] ad = 0;
   logic [7:0] wd = 0;
   wire  [7:0] rdata, fr;
   wire        scl, sda, st, sp, req, al;
   wire  [3:0] stat = {st, sp, req, al};
   int miscompares = 0, checked = 0;
   always #12.5 clk_in = ~clk_in;
   ibcf_bus_model bus_u (.scl_out(scl), .sda_out(sda));
   ibcf_flags dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
      .interface_enable_in(en), .communication_exit_request_in(ex),
      .start_request_set_in(rq), .start_done_in(dn), .reg_addr_in(ad), .reg_wdata_in(wd),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .start_detected_flag_out(st),
      .stop_detected_flag_out(sp), .start_request_out(req), .start_allowed_out(al),
      .flag_register_out(fr));
   task complete_run;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, s, e);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task wreg(input logic [7:0] d);
      @(posedge clk_in);
      wr <= 1;
      ad <= `IBCF_FLAG_ADDR;
      wd <= d;
      cyc(1);
      wr <= 0;
      cyc(2);
   endtask
   task rreg(input logic [19:0] a, input logic [7:0] e);
      @(posedge clk_in);
      rd <= 1;
      ad <= a;
      cyc(1);
      rd <= 0;
      cyc(1);
      chk(rdata, e);
   endtask
   // One-cycle strobe: 0 start request, 1 exit request, 2 start done
   task pulse(input int sel);
      @(posedge clk_in);
      rq <= (sel == 0);
      ex <= (sel == 1);
      dn <= (sel == 2);
      cyc(1);
      rq <= 0;
      ex <= 0;
      dn <= 0;
      cyc(3);
   endtask
   task enable(input logic b);
      @(posedge clk_in);
      en <= b;
      cyc(3);
   endtask
   initial
   begin
      #1000000;
      miscompares++;
      complete_run;
   end
   initial
   begin
      cyc(16);
      sys_rst_in <= 0;
      rreg(`IBCF_FLAG_ADDR, 8'h00);
      rreg(20'h00000, 8'h00);
      wreg(8'hFF);
      chk(fr, 8'h03);
      wreg(8'h00);
      enable(1);
      chk(fr, 8'h40);
      chk({4'h0, stat}, 8'h00);
      bus_u.stop;
      cyc(8);
      chk({fr[6], 3'h0, stat}, 8'h05);
      bus_u.start;
      cyc(8);
      chk({fr[6], 3'h0, stat}, 8'h8C);
      bus_u.clocks(9);
      cyc(8);
      chk({4'h0, stat}, 8'h08);
      bus_u.clocks(1);
      cyc(8);
      chk({4'h0, stat}, 8'h00);
      bus_u.stop;
      cyc(8);
      enable(0);
      wreg(8'h01);
      enable(1);
      rreg(`IBCF_FLAG_ADDR, 8'h41);
      pulse(0);
      chk(fr, 8'hC1);
      chk({4'h0, stat}, 8'h00);
      enable(0);
      chk(fr, 8'h01);
      wreg(8'h02);
      enable(1);
      chk(fr, 8'h02);
      chk({4'h0, stat}, 8'h01);
      // Write while enabled must be dropped by the device
      wreg(8'h01);
      chk(fr, 8'h02);
      // bus model idle before second start
      bus_u.start;
      cyc(8);
      chk(fr, 8'h40);
      // Reservation enabled, so a request on a busy bus stays pending
      pulse(0);
      chk({4'h0, stat}, 8'h0A);
      pulse(2);
      chk({4'h0, stat}, 8'h08);
      pulse(1);
      chk({4'h0, stat}, 8'h00);
      bus_u.stop;
      cyc(8);
      chk({fr[6], 3'h0, stat}, 8'h05);
      enable(0);
      wreg(8'h03);
      sys_rst_in <= 1;
      cyc(2);
      sys_rst_in <= 0;
      chk(fr, 8'h00);
      complete_run;
   end
endmodule // ibcf_flags_tb
